// ===== verilog/sfb_pkg.sv
// Constants for the serial flow control and break block
package sfb_pkg;
    localparam int unsigned ADDR_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL       = 6'h00;
    localparam logic [5:0] IDX_STATUS     = 6'h01;
    localparam logic [5:0] IDX_STOP_CODE  = 6'h05;
    localparam logic [5:0] IDX_RESUME     = 6'h06;
    localparam logic [5:0] IDX_BRK_LEN    = 6'h07;
    localparam logic [5:0] IDX_BLOCKS     = 6'h08;
    localparam logic [5:0] IDX_LOW_MARK   = 6'h09;
    localparam logic [5:0] IDX_HIGH_MARK  = 6'h0a;
    localparam logic [5:0] IDX_IRQ_STAT   = 6'h10;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h11;
    localparam logic [5:0] IDX_RING_LEVEL = 6'h12;
    // Control register fields
    localparam int unsigned CTRL_FLOW_LSB = 0;
    localparam int unsigned CTRL_BRK_EN   = 2;
    localparam int unsigned CTRL_BRK_REQ  = 3;
    // Event bits, shared by irq status and mask
    localparam int unsigned EV_W          = 5;
    localparam int unsigned EV_ILLEGAL    = 0;
    localparam int unsigned EV_BRK_DONE   = 1;
    localparam int unsigned EV_TX_HALT    = 2;
    localparam int unsigned EV_OVERRUN    = 3;
    localparam int unsigned EV_SUSPEND    = 4;
    // Reset values
    localparam logic [7:0] RST_STOP_CODE  = 8'h13;
    localparam logic [7:0] RST_RESUME     = 8'h11;
    localparam logic [7:0] RST_BRK_LEN    = 8'h0a;
    localparam logic [7:0] RST_BLOCKS     = 8'h01;
    localparam logic [7:0] RST_LOW_MARK   = 8'h20;
    localparam logic [7:0] RST_HIGH_MARK  = 8'h20;
    // Ring block size in bytes, as a shift
    localparam int unsigned BLOCK_SHIFT   = 7;
    localparam int unsigned LEVEL_W       = 16;
    // One millisecond and the clock period, in ns
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned CLK_NS        = 8;
    localparam int unsigned CYC_PER_MS    = MS_NS / CLK_NS;
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {
        FLOW_NONE,
        FLOW_STOP_RESUME,
        FLOW_ANY_RESUME,
        FLOW_HANDSHAKE
    } sfb_flow_e;

    typedef enum logic {
        BRK_IDLE,
        BRK_RUN
    } sfb_brk_e;
endpackage

// ===== verilog/sfb_flow_break.sv
// Flow control, break generation and receive ring watermarks
// Functional notes
// - In stop/resume or any-resume mode, stop code halts transmitter.
// - In stop/resume mode, resume code restarts halted transmitter.
// - Break is driven only while break request and break enable are set.
// - Break lasts break_length_ms milliseconds, up to 255 ms.
// - Break request clears itself when the break finishes.
// - Ring capacity is block count times 128 bytes.
// - Block count of zero is refused and sets the illegal flag.
// - Suspended input restarts when stored bytes drop below low mark.
// - Input suspends when free bytes fall below the high mark.
// - Mode 00 none, 01 stop/resume, 10 any-resume, 11 handshake.
// - Suspend sends stop code or negates RTS; resume the reverse.
// - Any-resume restarts on any char; handshake follows CTS.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module sfb_flow_break
    import sfb_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_data,
    input  wire logic              ring_pop,
    input  wire logic              tx_in_valid,
    input  wire logic [7:0]        tx_in_data,
    output logic                   tx_in_ready,
    output logic                   tx_out_valid,
    output logic [7:0]             tx_out_data,
    input  wire logic              tx_out_ready,
    input  wire logic              cts_pin,
    output logic                   rts_n,
    output logic                   break_out,
    output logic [1:0]             flow_ctl_sel,
    output logic                   illegal_cfg_flag,
    output logic                   irq
);

    generate
        if (CYC_MS < 2 || CYC_MS > 131071) begin : g_bad_ms
            $error("CYC_MS out of range");
        end
    endgenerate

    // Bus write and read channels
    logic              aw_have_q;
    logic [5:0]        aw_idx_q;
    logic              w_have_q;
    logic [7:0]        w_byte_q;
    logic              w_lane_q;
    logic              wr_fire;
    logic              wr_hit;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rd_val;
    logic              rd_hit;

    // Configuration
    logic [1:0]        flow_q;
    logic              brk_en_q;
    logic              brk_req_q;
    logic [7:0]        stop_q;
    logic [7:0]        resume_q;
    logic [7:0]        brk_len_q;
    logic [7:0]        blocks_q;
    logic [7:0]        low_q;
    logic [7:0]        high_q;
    logic [EV_W-1:0]   irq_stat_q;
    logic [EV_W-1:0]   irq_mask_q;
    logic [EV_W-1:0]   ev;

    // Datapath state
    logic              cts_s1_q;
    logic              cts_q;
    logic              halted_q;
    logic              susp_q;
    logic              send_stop_q;
    logic              send_res_q;
    logic [LEVEL_W-1:0] level_q;
    logic [LEVEL_W-1:0] cap;
    logic [LEVEL_W-1:0] free_b;
    logic              is_stop;
    logic              is_res;
    logic              store;
    logic              push;
    logic              pop;
    logic              txv_q;
    logic [7:0]        txd_q;
    logic              load_ok;
    sfb_flow_e         mode;
    sfb_brk_e          brk_st_q;
    logic [16:0]       ms_cnt_q;
    logic [7:0]        ms_left_q;
    logic              ms_tick;
    logic              brk_done;
    logic              brk_abort;
    logic              brk_start;

    function automatic logic wsel(input logic [5:0] idx);
        return wr_fire && w_lane_q && aw_idx_q == idx;
    endfunction

    assign mode = sfb_flow_e'(flow_q);

    // Bus slave: address and data are taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[ADDR_W-1:2];
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_comb begin
        case (aw_idx_q)
            IDX_CTRL, IDX_STOP_CODE, IDX_RESUME, IDX_BRK_LEN,
            IDX_BLOCKS, IDX_LOW_MARK, IDX_HIGH_MARK,
            IDX_IRQ_STAT, IDX_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr[ADDR_W-1:2])
            IDX_CTRL: begin
                rd_val[CTRL_FLOW_LSB +: 2] = flow_q;
                rd_val[CTRL_BRK_EN]        = brk_en_q;
                rd_val[CTRL_BRK_REQ]       = brk_req_q;
            end
            IDX_STATUS:     rd_val[4:0] = {cts_q, brk_st_q == BRK_RUN,
                                           susp_q, halted_q, txv_q};
            IDX_STOP_CODE:  rd_val[7:0] = stop_q;
            IDX_RESUME:     rd_val[7:0] = resume_q;
            IDX_BRK_LEN:    rd_val[7:0] = brk_len_q;
            IDX_BLOCKS:     rd_val[7:0] = blocks_q;
            IDX_LOW_MARK:   rd_val[7:0] = low_q;
            IDX_HIGH_MARK:  rd_val[7:0] = high_q;
            IDX_IRQ_STAT:   rd_val[EV_W-1:0] = irq_stat_q;
            IDX_IRQ_MASK:   rd_val[EV_W-1:0] = irq_mask_q;
            IDX_RING_LEVEL: rd_val[LEVEL_W-1:0] = level_q;
            default:        rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flow_q    <= 2'b00;
            brk_en_q  <= 1'b0;
            brk_req_q <= 1'b0;
        end else if (wsel(IDX_CTRL)) begin
            flow_q    <= w_byte_q[CTRL_FLOW_LSB +: 2];
            brk_en_q  <= w_byte_q[CTRL_BRK_EN];
            brk_req_q <= w_byte_q[CTRL_BRK_REQ];
        end else if (brk_done) begin
            brk_req_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_q    <= RST_STOP_CODE;
            resume_q  <= RST_RESUME;
            brk_len_q <= RST_BRK_LEN;
            low_q     <= RST_LOW_MARK;
            high_q    <= RST_HIGH_MARK;
        end else begin
            if (wsel(IDX_STOP_CODE)) stop_q <= w_byte_q;
            if (wsel(IDX_RESUME)) resume_q <= w_byte_q;
            if (wsel(IDX_BRK_LEN)) brk_len_q <= w_byte_q;
            if (wsel(IDX_LOW_MARK)) low_q <= w_byte_q;
            if (wsel(IDX_HIGH_MARK)) high_q <= w_byte_q;
        end
    end

    // zero block count is refused; old size stays
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blocks_q <= RST_BLOCKS;
        end else if (wsel(IDX_BLOCKS) && w_byte_q != 8'h00) begin
            blocks_q <= w_byte_q;
        end
    end

    // Interrupts: set wins over a write-one clear
    always_comb begin
        ev = '0;
        ev[EV_ILLEGAL]  = wsel(IDX_BLOCKS) && w_byte_q == 8'h00;
        ev[EV_BRK_DONE] = brk_done;
        ev[EV_TX_HALT]  = !halted_q && mode != FLOW_NONE && mode !=
                          FLOW_HANDSHAKE && rx_valid && is_stop;
        ev[EV_OVERRUN]  = store && !push;
        ev[EV_SUSPEND]  = !susp_q && mode != FLOW_NONE &&
                          free_b < LEVEL_W'(high_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
        end else if (wsel(IDX_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~w_byte_q[EV_W-1:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= '0;
        end else if (wsel(IDX_IRQ_MASK)) begin
            irq_mask_q <= w_byte_q[EV_W-1:0];
        end
    end

    assign irq              = |(irq_stat_q & irq_mask_q);
    assign illegal_cfg_flag = irq_stat_q[EV_ILLEGAL];
    assign flow_ctl_sel     = flow_q;

    // CTS comes from a pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cts_s1_q <= 1'b0;
            cts_q    <= 1'b0;
        end else begin
            cts_s1_q <= cts_pin;
            cts_q    <= cts_s1_q;
        end
    end

    assign cap     = LEVEL_W'({blocks_q, {BLOCK_SHIFT{1'b0}}});
    assign free_b  = (level_q < cap) ? cap - level_q : '0;
    assign is_stop = rx_data == stop_q;
    assign is_res  = rx_data == resume_q;
    // Stop code in the character modes, and resume code in stop/resume mode, are consumed, not stored
    assign store   = rx_valid && !((mode == FLOW_STOP_RESUME &&
                     (is_stop || is_res)) ||
                     (mode == FLOW_ANY_RESUME && is_stop));
    assign push    = store && level_q < cap;
    assign pop     = ring_pop && level_q != '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= '0;
        end else if (push && !pop) begin
            level_q <= level_q + 1'b1;
        end else if (pop && !push) begin
            level_q <= level_q - 1'b1;
        end
    end

    // mode decode drives the transmit halt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halted_q <= 1'b0;
        end else begin
            case (mode)
                FLOW_NONE: halted_q <= 1'b0;
                FLOW_HANDSHAKE: halted_q <= !cts_q;
                FLOW_STOP_RESUME: begin
                    if (rx_valid && is_stop) halted_q <= 1'b1;
                    else if (rx_valid && is_res) halted_q <= 1'b0;
                end
                FLOW_ANY_RESUME: begin
                    if (rx_valid && is_stop) halted_q <= 1'b1;
                    else if (rx_valid) halted_q <= 1'b0;
                end
                default: halted_q <= 1'b0;
            endcase
        end
    end

    // Input suspend and resume against the watermarks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            susp_q      <= 1'b0;
            send_stop_q <= 1'b0;
            send_res_q  <= 1'b0;
        end else begin
            if (mode == FLOW_NONE) begin
                susp_q <= 1'b0;
            // suspend on too little free space
            end else if (!susp_q && free_b < LEVEL_W'(high_q)) begin
                susp_q <= 1'b1;
            end else if (susp_q && level_q < LEVEL_W'(low_q)) begin
                susp_q <= 1'b0;
            end
            // character modes queue a stop or resume code
            if (mode == FLOW_STOP_RESUME || mode == FLOW_ANY_RESUME) begin
                if (ev[EV_SUSPEND]) begin
                    send_stop_q <= 1'b1;
                    send_res_q  <= 1'b0;
                end else if (susp_q && level_q < LEVEL_W'(low_q)) begin
                    send_res_q  <= 1'b1;
                    send_stop_q <= 1'b0;
                end else if (load_ok && send_stop_q) begin
                    send_stop_q <= 1'b0;
                end else if (load_ok && send_res_q) begin
                    send_res_q <= 1'b0;
                end
            end else begin
                send_stop_q <= 1'b0;
                send_res_q  <= 1'b0;
            end
        end
    end

    // handshake mode negates RTS while suspended
    assign rts_n = !(mode == FLOW_HANDSHAKE) || susp_q;

    // Transmit stage; flow codes jump ahead of user data
    assign load_ok = (!txv_q || tx_out_ready) && brk_st_q == BRK_IDLE;
    // source is held off, not dropped, while halted
    assign tx_in_ready = load_ok && !halted_q && !send_stop_q &&
                         !send_res_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txv_q <= 1'b0;
            txd_q <= 8'h00;
        end else if (load_ok && send_stop_q) begin
            txv_q <= 1'b1;
            txd_q <= stop_q;
        end else if (load_ok && send_res_q) begin
            txv_q <= 1'b1;
            txd_q <= resume_q;
        end else if (tx_in_ready && tx_in_valid) begin
            txv_q <= 1'b1;
            txd_q <= tx_in_data;
        end else if (tx_out_ready) begin
            txv_q <= 1'b0;
        end
    end

    assign tx_out_valid = txv_q;
    assign tx_out_data  = txd_q;

    // Break timer; a millisecond counter would overflow a short width
    assign ms_tick   = ms_cnt_q == 17'(CYC_MS - 1);
    // break needs both request and enable
    assign brk_start = brk_st_q == BRK_IDLE && brk_req_q && brk_en_q;
    assign brk_abort = brk_st_q == BRK_RUN && !(brk_req_q && brk_en_q);
    assign brk_done  = (brk_start && brk_len_q == 8'h00) ||
                       (brk_st_q == BRK_RUN && !brk_abort &&
                        ms_tick && ms_left_q == 8'h01);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_st_q  <= BRK_IDLE;
            ms_cnt_q  <= '0;
            ms_left_q <= 8'h00;
        end else begin
            case (brk_st_q)
                BRK_IDLE: begin
                    ms_cnt_q  <= '0;
                    ms_left_q <= brk_len_q;
                    if (brk_start && brk_len_q != 8'h00) begin
                        brk_st_q <= BRK_RUN;
                    end
                end
                BRK_RUN: begin
                    if (brk_abort || brk_done) begin
                        brk_st_q <= BRK_IDLE;
                    end else if (ms_tick) begin
                        ms_cnt_q  <= '0;
                        ms_left_q <= ms_left_q - 1'b1;
                    end else begin
                        ms_cnt_q <= ms_cnt_q + 1'b1;
                    end
                end
                default: brk_st_q <= BRK_IDLE;
            endcase
        end
    end

    assign break_out = brk_st_q == BRK_RUN;

endmodule // sfb_flow_break

// ===== sim/sfb_flow_break_checker.sv
// Port assertions for the flow control and break block
`timescale 1ns/1ps
module sfb_flow_break_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       tx_in_valid,
    input wire logic [7:0] tx_in_data,
    input wire logic       tx_in_ready,
    input wire logic       tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic       cts_pin,
    input wire logic       rts_n,
    input wire logic       break_out,
    input wire logic [1:0] flow_ctl_sel
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    a_rts_mode: assert property (
        !rts_n |-> flow_ctl_sel == 2'b11)
        else $error("rts asserted outside handshake mode");
    a_break_stops_tx: assert property (
        break_out |-> !tx_in_ready)
        else $error("data taken during break");
    a_cts_halts: assert property (
        (flow_ctl_sel == 2'b11 && !cts_pin) [*4] |-> !tx_in_ready)
        else $error("transmit not halted by cts");
    a_tx_in_order: assert property (
        tx_in_valid && tx_in_ready
        |=> tx_out_valid && tx_out_data == $past(tx_in_data))
        else $error("transmit byte lost");
    a_mode_by_write: assert property (
        $changed(flow_ctl_sel) && $past(aresetn) |-> s_axi_bvalid)
        else $error("mode changed without write");
endmodule // sfb_flow_break_checker

bind sfb_flow_break sfb_flow_break_checker u_chk (.*);

// ===== sim/sfb_remote.sv
// Model of the remote serial station on the line
`timescale 1ns/1ps
module sfb_remote (
    input  wire logic       aclk,
    input  wire logic       tx_out_valid,
    input  wire logic [7:0] tx_out_data,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_out_ready,
    output logic            cts_pin
);
    logic [7:0] got[$];
    logic       stall = 1'b0;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        cts_pin = 1'b1;
    end
    assign tx_out_ready = !stall;

    always @(posedge aclk) begin
        if (tx_out_valid && tx_out_ready) got.push_back(tx_out_data);
    end

    // Idle line shows the inverse, so a stale byte is never mistaken
    task automatic send(input logic [7:0] c);
        rx_valid <= 1'b1;
        rx_data <= c;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_data <= ~c;
        @(posedge aclk);
    endtask

    // CTS level and receive stall, changed only from here
    task automatic set_line(input logic c, input logic h);
        cts_pin <= c;
        stall <= h;
    endtask
endmodule // sfb_remote

// ===== sim/sfb_flow_break_test.sv
// Bench for the flow control and break block
`timescale 1ns/1ps
module sfb_flow_break_test
    import sfb_pkg::*;
;
    localparam int CYC = 10;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid, ring_pop;
    logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready, cts_pin;
    logic rts_n, break_out, illegal_cfg_flag, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, d;
    logic [7:0]        rx_data, tx_in_data, tx_out_data;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, flow_ctl_sel, r;
    logic [5:0]        ix[6] = '{IDX_STOP_CODE, IDX_RESUME, IDX_BRK_LEN,
                                IDX_BLOCKS, IDX_LOW_MARK, IDX_HIGH_MARK};
    logic [7:0]        rv[6] = '{RST_STOP_CODE, RST_RESUME, RST_BRK_LEN,
                                RST_BLOCKS, RST_LOW_MARK, RST_HIGH_MARK};
    int                num_errors = 0;
    int                comparisons = 0;
    int                n;

    sfb_flow_break #(.CYC_MS(CYC)) dut (.*);
    sfb_remote rem (.*);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] v,
                      input logic [1:0] er);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [5:0] i);
        s_axi_araddr <= {i, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic push(input logic [7:0] v);
        {tx_in_valid, tx_in_data} <= {1'b1, v};
        do @(posedge aclk); while (!tx_in_ready);
        tx_in_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic pop(input int k);
        ring_pop <= 1'b1;
        repeat (k) @(posedge aclk);
        ring_pop <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, ring_pop, tx_in_valid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_in_data} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ix[k]) begin
            rd(ix[k]);
            chk(d, rv[k]);
            wr(ix[k], 8'(k + 1), RESP_OKAY);
            rd(ix[k]);
            chk(d, k + 1);
            wr(ix[k], rv[k], RESP_OKAY);
        end
        wr(6'h3f, 8'h00, RESP_SLVERR);
        rd(6'h3f);
        chk(r, RESP_SLVERR);
        wr(IDX_BLOCKS, 8'h00, RESP_OKAY);
        rd(IDX_BLOCKS);
        chk(d, RST_BLOCKS);
        chk({irq, illegal_cfg_flag}, 2'b01);
        wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
        chk(irq, 1'b1);
        wr(IDX_IRQ_STAT, 8'h1f, RESP_OKAY);
        chk({irq, illegal_cfg_flag}, 2'b00);
        repeat (129) rem.send(8'h55);
        rd(IDX_RING_LEVEL);
        chk(d, 32'd128);
        rd(IDX_IRQ_STAT);
        chk(d[EV_OVERRUN], 1'b1);
        pop(128);
        wr(IDX_CTRL, 8'h01, RESP_OKAY);
        repeat (96) rem.send(8'h55);
        chk(rem.got.size(), 0);
        rem.send(8'h55);
        repeat (4) @(posedge aclk);
        chk(rem.got.pop_back(), RST_STOP_CODE);
        pop(65);
        chk(rem.got.size(), 0);
        pop(1);
        chk(rem.got.pop_back(), RST_RESUME);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CTRL, 8'(m), RESP_OKAY);
            chk({rts_n, flow_ctl_sel}, {m != 3, 2'(m)});
            if (m == 3) rem.set_line(1'b0, 1'b0);
            else rem.send(RST_STOP_CODE);
            repeat (4) @(posedge aclk);
            chk(tx_in_ready, m == 0);
            if (m == 3) rem.set_line(1'b1, 1'b0);
            else rem.send(8'h55);
            repeat (4) @(posedge aclk);
            chk(tx_in_ready, m != 1);
            rem.send(RST_RESUME);
            repeat (4) @(posedge aclk);
            chk(tx_in_ready, 1'b1);
        end
        repeat (59) rem.send(8'h55);
        repeat (2) @(posedge aclk);
        chk(rts_n, 1'b1);
        pop(66);
        chk(rts_n, 1'b0);
        wr(IDX_CTRL, 8'h01, RESP_OKAY);
        rem.set_line(1'b1, 1'b1);
        push(8'ha1);
        rem.send(RST_STOP_CODE);
        rd(IDX_STATUS);
        chk(d, 32'h13);
        fork
            begin
                repeat (20) @(posedge aclk);
                rem.set_line(1'b1, 1'b0);
                rem.send(RST_RESUME);
            end
        join_none
        push(8'ha2);
        repeat (8) @(posedge aclk);
        chk({rem.got[0], rem.got[1]}, 16'ha1a2);
        wr(IDX_BRK_LEN, 8'h03, RESP_OKAY);
        wr(IDX_CTRL, 8'h08, RESP_OKAY);
        repeat (8) @(posedge aclk);
        chk(break_out, 1'b0);
        n = 0;
        fork
            wr(IDX_CTRL, 8'h0c, RESP_OKAY);
            begin
                do @(posedge aclk); while (!break_out);
                while (break_out) begin
                    @(posedge aclk);
                    n++;
                end
            end
        join
        chk(n, 3 * CYC);
        rd(IDX_CTRL);
        chk(d[3:2], 2'b01);
        report_and_stop();
    end
endmodule // sfb_flow_break_test
